// ===== verification/pdsm_host_model.sv
// Host-side model issuing single-byte register accesses.
// Assumes the register port samples strobes on rising clk_in edges.
`timescale 1ns/100ps
module pdsm_host_model (
  // Bus
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic write_out = 1'b0,
  output logic read_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00
);
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    {write_out, addr_out, wdata_out} = {1'b1, a, d};
    @(posedge clk_in) #1;
    {write_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) #1;
    {read_out, addr_out} = {1'b1, a};
    @(posedge clk_in) #1;
    {read_out, addr_out} = {1'b0, ~a};
    d = rdata_in;
  endtask
endmodule // pdsm_host_model

// ===== verification/pdsm_regs_sva.sv
// Port assertions for the PD status and mask register slice.
// Assumes event pulses and the byte port are synchronous to clk_in.
`timescale 1ns/100ps
module pdsm_regs_sva (
  // Clock, reset, register port
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Device side
  input wire pdsm_pkg::pdsm_event_type event_in,
  input wire pdsm_pkg::pdsm_toggle_type toggle_in,
  input wire logic [1:0] internal_power_req_in,
  input wire logic [3:0] power_enable_field_in,
  input wire logic ack_sent_irq_out,
  input wire logic [3:0] effective_power_out,
  input wire logic toggle_stopped_out,
  input wire logic [2:0] toggle_settle_state_out
);
  logic mask_reg;
  logic [1:0] req_reg;
  wire logic at_mask = reg_addr_in == 8'h0f;
  wire logic rd_stat = reg_read_in && reg_addr_in == 8'h3c;
  wire logic mapped = at_mask || reg_addr_in == 8'h00 ||
                      reg_addr_in == 8'h3c || reg_addr_in == 8'h3d;
  wire logic clr = event_in.tx_start_cmd | event_in.transmitter_on_cmd |
                   event_in.send_hard_reset_cmd;
  // Status capture delays the internal request one cycle before the combine
  wire logic [3:0] mix = {req_reg, power_enable_field_in[1:0]};
  wire logic [3:0] pmax = (mix > power_enable_field_in) ? mix :
                          power_enable_field_in;
  wire logic [2:0] st = toggle_settle_state_out;
  wire logic idle = toggle_in.toggle_enable && st == 3'h0;
  // Shadows of the mask bit and the delayed request, since the checker cannot see inside
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mask_reg <= 1'b0;
      req_reg <= 2'h0;
    end else begin
      req_reg <= internal_power_req_in;
      if (reg_write_in && at_mask) begin
        mask_reg <= reg_wdata_in[0];
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence retry_set_s;
    event_in.packet_retries_done ##1 !clr ##1 rd_stat;
  endsequence
  sequence fail_clear_s;
    clr && !event_in.packet_retries_done && !event_in.soft_reset_retries_done
      ##1 !event_in.packet_retries_done && !event_in.soft_reset_retries_done
      ##1 rd_stat;
  endsequence
  sequence soft_set_s;
    event_in.soft_reset_retries_done ##1 !clr ##1 rd_stat;
  endsequence
  sequence hard_rx_s;
    event_in.hard_reset_rx ##1 rd_stat;
  endsequence
  ack_irq_a: assert property (!$past(reset_in) |-> ack_sent_irq_out ==
    $past(event_in.ack_sent && !mask_reg)) else $error("ack irq wrong");
  mask_read_a: assert property (reg_read_in && at_mask |=>
    reg_rdata_out == {7'h00, $past(mask_reg)}) else $error("mask readback");
  retry_set_a: assert property (retry_set_s |=> reg_rdata_out[4])
    else $error("retry fail flag not set");
  soft_set_a: assert property (soft_set_s |=> reg_rdata_out[5])
    else $error("soft reset fail flag not set");
  hard_rx_a: assert property (hard_rx_s |=> reg_rdata_out[0])
    else $error("hard reset flag not set");
  fail_clear_a: assert property (fail_clear_s |=>
    reg_rdata_out[5:4] == 2'b00) else $error("fail flags not cleared");
  power_a: assert property (!$past(reset_in) |->
    effective_power_out == $past(pmax)) else $error("power combine wrong");
  unmapped_a: assert property (reg_read_in && !mapped |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  stopped_a: assert property (toggle_stopped_out == (st != 3'h0))
    else $error("stopped flag disagrees with code");
  drop_a: assert property (!toggle_in.toggle_enable |=> st == 3'h0)
    else $error("code not cleared");
  hold_a: assert property (toggle_in.toggle_enable && st != 3'h0 |=>
    $stable(st)) else $error("settled code changed");
  src1_a: assert property (idle && toggle_in.cc1_source &&
    !toggle_in.audio_ra_both |=> st == 3'h1) else $error("source cc1 code");
  audio_a: assert property (idle && toggle_in.audio_ra_both &&
    !toggle_in.sink_only_mode |=> st == 3'h7) else $error("audio code");
endmodule // pdsm_regs_sva
bind pdsm_regs pdsm_regs_sva u_sva (.clk_in, .reset_in, .reg_write_in,
  .reg_read_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .event_in,
  .toggle_in, .internal_power_req_in, .power_enable_field_in,
  .ack_sent_irq_out, .effective_power_out, .toggle_stopped_out,
  .toggle_settle_state_out);

// ===== verification/pdsm_regs_tb_top.sv
// Self-checking bench for the PD status and mask register slice.
// Assumes the host model drives the byte port; events come from here.
`timescale 1ns/100ps
module pdsm_regs_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  pdsm_pkg::pdsm_event_type ev = '0;
  pdsm_pkg::pdsm_toggle_type tg = '0;
  logic [1:0] preq = 2'b00;
  logic [3:0] pfld = 4'h0;
  logic we, re, irq, stop;
  logic [7:0] addr, wdat, rdat, v;
  logic [3:0] epw;
  logic [2:0] code;
  logic [7:0] adr [5] = '{8'h00, 8'h0f, 8'h3c, 8'h3d, 8'h55};
  logic [9:0] pw [3] = '{10'h3f3, 10'h3cf, 10'h265};
  logic [9:0] tt [7] = '{10'h040, 10'h0d0, 10'h148, 10'h2c4, 10'h342,
                         10'h3c1, 10'h3e1};
  int n_errors = 0;
  int tests_run = 0;
  always #2 clk_in = ~clk_in;
  pdsm_host_model u_host (.clk_in, .rdata_in(rdat), .write_out(we),
    .read_out(re), .addr_out(addr), .wdata_out(wdat));
  pdsm_regs u_dut (.clk_in, .reset_in, .reg_write_in(we), .reg_read_in(re),
    .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
    .event_in(ev), .toggle_in(tg), .internal_power_req_in(preq),
    .power_enable_field_in(pfld), .ack_sent_irq_out(irq),
    .effective_power_out(epw), .toggle_stopped_out(stop),
    .toggle_settle_state_out(code));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, v);
    check(v, exp);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clk_in) #1;
    ev = m;
    @(posedge clk_in) #1;
    ev = '0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1 reset_in = 1'b0;
    foreach (adr[i]) rchk(adr[i], 8'h00);
    foreach (adr[i]) u_host.wr(adr[i], 8'hff);
    foreach (adr[i]) rchk(adr[i], i < 2 ? 8'h01 : 8'h00);
    $display("test registers done");
    pulse(11'h008);
    check({7'h00, irq}, 8'h00);
    u_host.wr(8'h0f, 8'h00);
    pulse(11'h008);
    check({7'h00, irq}, 8'h01);
    $display("test ack mask done");
    for (int k = 6; k < 9; k++) begin
      pulse(11'h600);
      rchk(8'h3c, 8'h30);
      pulse(11'h001 << k);
      rchk(8'h3c, 8'h00);
    end
    pulse(11'h300);
    rchk(8'h3c, 8'h10);
    pulse(11'h100);
    rchk(8'h3c, 8'h00);
    $display("test fail flags done");
    // Entries hold expected power, internal request, software field
    foreach (pw[i]) begin
      {preq, pfld} = pw[i][5:0];
      rchk(8'h3c, {4'h0, preq, 2'b00});
      check({4'h0, epw}, {4'h0, pw[i][9:6]});
    end
    preq = 2'b00;
    $display("test power done");
    pulse(11'h020);
    rchk(8'h3c, 8'h02);
    pulse(11'h010);
    rchk(8'h3c, 8'h03);
    for (int k = 0; k < 4; k++) begin
      pulse({8'h01, k[1:0]});
      rchk(8'h3d, k < 3 ? 8'h01 << k : 8'h00);
    end
    $display("test received types done");
    // Entries hold expected code above the toggle detector levels
    foreach (tt[i]) begin
      tg = tt[i][6:0];
      rchk(8'h3d, {2'b00, tt[i][9:7], 3'b000});
      check({4'h0, stop, code}, {4'h0, |tt[i][9:7], tt[i][9:7]});
      tg = '0;
      @(posedge clk_in) #1;
    end
    u_host.wr(8'h00, 8'h00);
    tg = 7'h61;
    rchk(8'h3d, 8'h00);
    $display("test toggle done");
    final_report();
  end
  initial begin
    #40000;
    n_errors++;
    final_report();
  end
endmodule // pdsm_regs_tb_top

// ===== verilog/pdsm_pkg.sv
// Constants and carrier types for the PD status and mask register slice.
// Assumes one device clock and a plain byte-wide register access port.
// What this block does
// RQ1 - Mask bit 0 blocks ack-sent interrupt
// RQ2 - Audio-exit bit stops sink toggle on Ra-Ra
// RQ3 - Set soft_reset_failed bit 5 after all retries
// RQ4 - Set retries_failed bit 4 after all retries
// RQ5 - Transmit start, tx-on, hard-reset clear both fails
// RQ6 - Report internal power request bits 3:2, max combine
// RQ7 - Set soft_reset_received bit 1 on soft reset
// RQ8 - Set hard_reset_received bit 0 on hard reset
// RQ9 - Settle state reads 000 while toggling
// RQ10 - Settle 001 source CC1, 010 source CC2
// RQ11 - Settle 101 sink CC1, 110 sink CC2
// RQ12 - Settle 111 on audio, then source CC1
// RQ13 - Flag SOP type of last received packet
// RQ14 - Raise ack-sent interrupt on GoodCRC sent
// RQ15 - Reserved bits read zero, ignore writes
package pdsm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TOGGLE_EXIT_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] GCRC_SENT_IRQ_MASK_ADDR = 8'h0f;
  localparam logic [7:0] RESET_RETRY_POWER_STATUS_ADDR = 8'h3c;
  localparam logic [7:0] TOGGLE_SOP_STATUS_ADDR = 8'h3d;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] TOGGLE_EXIT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] GCRC_SENT_IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int STOP_ON_AUDIO_BIT = 0;
  localparam int ACK_MASK_BIT = 0;
  localparam int SOFT_FAIL_BIT = 5;
  localparam int RETRY_FAIL_BIT = 4;
  localparam int POWER_REQ_LSB = 2;
  localparam int SOFT_RX_BIT = 1;
  localparam int HARD_RX_BIT = 0;
  localparam int SETTLE_LSB = 3;

  // ****************************************
  // Toggle settle-state codes
  // ****************************************
  localparam logic [2:0] SETTLE_RUNNING = 3'h0;
  localparam logic [2:0] SETTLE_SRC_CC1 = 3'h1;
  localparam logic [2:0] SETTLE_SRC_CC2 = 3'h2;
  localparam logic [2:0] SETTLE_SNK_CC1 = 3'h5;
  localparam logic [2:0] SETTLE_SNK_CC2 = 3'h6;
  localparam logic [2:0] SETTLE_AUDIO = 3'h7;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef enum logic [1:0] {
    PDSM_SOP_PLAIN,
    PDSM_SOP_PRIME_DEBUG,
    PDSM_SOP_DPRIME_DEBUG,
    PDSM_SOP_OTHER
  } pdsm_sop_type;

  // Events from the transmitter and receiver, one-cycle pulses
  typedef struct packed {
    logic soft_reset_retries_done;
    logic packet_retries_done;
    logic tx_start_cmd;
    logic transmitter_on_cmd;
    logic send_hard_reset_cmd;
    logic soft_reset_rx;
    logic hard_reset_rx;
    logic ack_sent;
    logic rx_fifo_write;
    pdsm_sop_type rx_sop;
  } pdsm_event_type;

  // Toggle detector view, levels
  typedef struct packed {
    logic toggle_enable;
    logic sink_only_mode;
    logic cc1_source;
    logic cc2_source;
    logic cc1_sink;
    logic cc2_sink;
    logic audio_ra_both;
  } pdsm_toggle_type;

endpackage

// ===== verilog/pdsm_regs.sv
// Register slice: ack-sent mask, toggle audio exit, two status registers.
// Assumes a synchronous byte register port driven by the serial decoder.
`timescale 1ns/100ps
module pdsm_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register access port
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Device events and state
  input wire pdsm_pkg::pdsm_event_type event_in,
  input wire pdsm_pkg::pdsm_toggle_type toggle_in,
  input wire logic [1:0] internal_power_req_in,
  input wire logic [3:0] power_enable_field_in,
  // Outputs to the device
  output logic ack_sent_irq_out,
  output logic [3:0] effective_power_out,
  output logic toggle_stopped_out,
  output logic [2:0] toggle_settle_state_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] max4(input logic [3:0] a,
                                      input logic [3:0] b);
    max4 = (a > b) ? a : b;
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  logic toggle_stop_on_audio_reg;
  logic ack_sent_irq_mask_reg;
  logic soft_reset_failed_reg;
  logic retries_failed_reg;
  logic [1:0] internal_power_req_reg;
  logic soft_reset_received_reg;
  logic hard_reset_received_reg;
  logic rx_type_plain_reg;
  logic rx_type_prime_debug_reg;
  logic rx_type_dprime_debug_reg;
  logic ack_sent_irq_reg;
  logic [3:0] power_reg;
  logic [7:0] rdata_reg;
  logic [2:0] settle_state;
  logic stopped;

  wire logic wr_ctrl = reg_write_in &
    (reg_addr_in == pdsm_pkg::TOGGLE_EXIT_CONTROL_ADDR);
  wire logic wr_mask = reg_write_in &
    (reg_addr_in == pdsm_pkg::GCRC_SENT_IRQ_MASK_ADDR);
  // Clear commands lose to a same-cycle failure so no event is dropped
  wire logic fail_clear = event_in.tx_start_cmd |
    event_in.transmitter_on_cmd | event_in.send_hard_reset_cmd; // RQ5
  wire logic soft_fail_next = event_in.soft_reset_retries_done |
    (soft_reset_failed_reg & !fail_clear); // RQ3 RQ5
  wire logic retry_fail_next = event_in.packet_retries_done |
    (retries_failed_reg & !fail_clear); // RQ4 RQ5
  wire logic rx_wr = event_in.rx_fifo_write;

  // Reserved bits are simply absent from the stored state and read zero
  wire logic [7:0] status0 = {2'h0,
    soft_reset_failed_reg, retries_failed_reg,
    internal_power_req_reg,
    soft_reset_received_reg, hard_reset_received_reg}; // RQ15
  wire logic [7:0] status1 = {2'h0, settle_state,
    rx_type_dprime_debug_reg, rx_type_prime_debug_reg,
    rx_type_plain_reg}; // RQ15
  wire logic [7:0] rdata_next =
    (reg_addr_in == pdsm_pkg::TOGGLE_EXIT_CONTROL_ADDR) ?
      {7'h00, toggle_stop_on_audio_reg} :
    (reg_addr_in == pdsm_pkg::GCRC_SENT_IRQ_MASK_ADDR) ?
      {7'h00, ack_sent_irq_mask_reg} :
    (reg_addr_in == pdsm_pkg::RESET_RETRY_POWER_STATUS_ADDR) ? status0 :
    (reg_addr_in == pdsm_pkg::TOGGLE_SOP_STATUS_ADDR) ? status1 : 8'h00;
  // Internal request fills bits 3:2, software bits 1:0 pass unchanged
  wire logic [3:0] internal_power = {internal_power_req_reg,
    power_enable_field_in[1:0]};

  // ****************************************
  // Toggle settle tracker
  // ****************************************
  pdsm_settle settle_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .stop_on_audio_in(toggle_stop_on_audio_reg),
    .toggle_in(toggle_in),
    .settle_state_out(settle_state),
    .toggle_stopped_out(stopped)
  );

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      toggle_stop_on_audio_reg <=
        pdsm_pkg::TOGGLE_EXIT_CONTROL_RESET[pdsm_pkg::STOP_ON_AUDIO_BIT];
      ack_sent_irq_mask_reg <=
        pdsm_pkg::GCRC_SENT_IRQ_MASK_RESET[pdsm_pkg::ACK_MASK_BIT];
    end else begin
      if (wr_ctrl) begin
        toggle_stop_on_audio_reg <=
          reg_wdata_in[pdsm_pkg::STOP_ON_AUDIO_BIT]; // RQ15
      end
      if (wr_mask) begin
        ack_sent_irq_mask_reg <= reg_wdata_in[pdsm_pkg::ACK_MASK_BIT]; // RQ15
      end
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      soft_reset_failed_reg <= pdsm_pkg::STATUS_RESET[pdsm_pkg::SOFT_FAIL_BIT];
      retries_failed_reg <= pdsm_pkg::STATUS_RESET[pdsm_pkg::RETRY_FAIL_BIT];
      internal_power_req_reg <= 2'h0;
      soft_reset_received_reg <= pdsm_pkg::STATUS_RESET[pdsm_pkg::SOFT_RX_BIT];
      hard_reset_received_reg <= pdsm_pkg::STATUS_RESET[pdsm_pkg::HARD_RX_BIT];
      rx_type_plain_reg <= 1'b0;
      rx_type_prime_debug_reg <= 1'b0;
      rx_type_dprime_debug_reg <= 1'b0;
    end else begin
      soft_reset_failed_reg <= soft_fail_next; // RQ3
      retries_failed_reg <= retry_fail_next; // RQ4
      internal_power_req_reg <= internal_power_req_in; // RQ6
      if (event_in.soft_reset_rx) begin
        soft_reset_received_reg <= 1'b1; // RQ7
      end
      if (event_in.hard_reset_rx) begin
        hard_reset_received_reg <= 1'b1; // RQ8
      end
      if (rx_wr) begin
        rx_type_plain_reg <=
          event_in.rx_sop == pdsm_pkg::PDSM_SOP_PLAIN; // RQ13
        rx_type_prime_debug_reg <=
          event_in.rx_sop == pdsm_pkg::PDSM_SOP_PRIME_DEBUG; // RQ13
        rx_type_dprime_debug_reg <=
          event_in.rx_sop == pdsm_pkg::PDSM_SOP_DPRIME_DEBUG; // RQ13
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_sent_irq_reg <= 1'b0;
      power_reg <= 4'h0;
      rdata_reg <= 8'h00;
    end else begin
      ack_sent_irq_reg <= event_in.ack_sent & !ack_sent_irq_mask_reg; // RQ1 RQ14
      power_reg <= max4(power_enable_field_in, internal_power); // RQ6
      if (reg_read_in) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign ack_sent_irq_out = ack_sent_irq_reg;
  assign effective_power_out = power_reg;
  assign toggle_stopped_out = stopped;
  assign toggle_settle_state_out = settle_state;

endmodule // pdsm_regs

// ===== verilog/pdsm_settle.sv
// Toggle settle-state tracker.
// Assumes detection levels are synchronous to clk_in.
`timescale 1ns/100ps
module pdsm_settle (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control
  input wire logic stop_on_audio_in,
  input wire pdsm_pkg::pdsm_toggle_type toggle_in,
  // State
  output logic [2:0] settle_state_out,
  output logic toggle_stopped_out
);

  logic [2:0] settle_reg;
  logic [2:0] settle_next;
  logic stopped_reg;
  wire logic running = settle_reg == pdsm_pkg::SETTLE_RUNNING;
  wire logic audio_stop = toggle_in.audio_ra_both &
    (!toggle_in.sink_only_mode | stop_on_audio_in); // RQ2
  wire logic [2:0] detect_code =
    audio_stop ? pdsm_pkg::SETTLE_AUDIO : // RQ12
    toggle_in.cc1_source ? pdsm_pkg::SETTLE_SRC_CC1 : // RQ10
    toggle_in.cc2_source ? pdsm_pkg::SETTLE_SRC_CC2 : // RQ10
    toggle_in.cc1_sink ? pdsm_pkg::SETTLE_SNK_CC1 : // RQ11
    toggle_in.cc2_sink ? pdsm_pkg::SETTLE_SNK_CC2 : // RQ11
    pdsm_pkg::SETTLE_RUNNING;

  // Once settled the code holds until software drops the toggle enable
  assign settle_next = !toggle_in.toggle_enable ? pdsm_pkg::SETTLE_RUNNING :
    running ? detect_code : settle_reg; // RQ9

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      settle_reg <= pdsm_pkg::SETTLE_RUNNING;
      stopped_reg <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      stopped_reg <= settle_next != pdsm_pkg::SETTLE_RUNNING; // RQ2
    end
  end

  assign settle_state_out = settle_reg;
  assign toggle_stopped_out = stopped_reg;

endmodule // pdsm_settle
